// *** logic/power_fifo_cfg.svh ***
/*
  offsets, field positions, reset values and codes of the power and queue register bank.
  assumes it is included by its bare name from the bank module.
*/
`ifndef POWER_FIFO_CFG_SVH
`define POWER_FIFO_CFG_SVH

// register offsets on the seven-bit register address
`define ADDR_POWER_CLOCK 7'h6B
`define ADDR_AXIS_STANDBY 7'h6C
`define ADDR_LEVEL_HIGH 7'h72
`define ADDR_LEVEL_LOW 7'h73
`define ADDR_DATA_PORT 7'h74
`define ADDR_IDENTITY 7'h75

// power_clock_control fields
`define PWR_RESET_BIT 7
`define PWR_SLEEP_BIT 6
`define PWR_CYCLE_BIT 5
`define PWR_THERMAL_BIT 3
`define PWR_RESET_VALUE 8'h01
`define PWR_WRITE_MASK 8'h6F

// axis_standby_control fields
`define STBY_LP_BIT 7
`define STBY_X_BIT 5
`define STBY_Y_BIT 4
`define STBY_Z_BIT 3
`define STBY_RESET_VALUE 8'h00
`define STBY_WRITE_MASK 8'hB8

// clock source codes
`define CLK_INTERNAL_A 3'h0
`define CLK_PLL_FIRST 3'h1
`define CLK_PLL_LAST 3'h5
`define CLK_INTERNAL_B 3'h6
`define CLK_STOPPED 3'h7

// queue
`define QUEUE_DEPTH 13'h1000
`define QUEUE_EMPTY_MARK 8'hFF
`define QUEUE_SUBSTITUTE 8'hFE
`define SENSOR_BYTES 8

// serial bus address, low bit comes from the select pin
`define BUS_ADDRESS_BASE 7'h68

// arbitrary identity value, not tied to any real part
`define IDENTITY_DEFAULT 8'h5A

`endif

// *** logic/power_fifo_pkg.sv ***
/*
  types of the power and queue register bank.
  assumes nothing of its surroundings.
*/
package power_fifo_pkg;

  // duty cycling sequencer
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_DOZE,
    ST_SAMPLE
  } cycle_state_t;

endpackage : power_fifo_pkg

// *** logic/power_fifo_register_bank.sv ***
/*
  power, clock source, axis standby, byte queue and identity registers of a motion sensor.
  assumes a serial interface on i_link_clk issues one register access at a time and waits
  for o_reg_done; sensor data, rate ticks and the source enable flags come from i_clk logic.
*/
`timescale 1ns/10ps
`include "power_fifo_cfg.svh"

module power_fifo_register_bank #(
  parameter logic [7:0] IDENTITY_VALUE = `IDENTITY_DEFAULT // arbitrary value
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // link clock and reset
  input wire logic i_link_clk,
  input wire logic i_link_rst_b,
  // register access from the serial interface, link domain
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_done,
  output logic o_reg_busy,
  // bus address selection
  input wire logic i_address_select_pin,
  output logic [6:0] o_bus_address,
  // sensing side, core domain
  input wire logic i_pll_ready,
  input wire logic i_wake_tick,
  input wire logic i_sample_tick,
  input wire logic [63:0] i_sensor_bytes,
  input wire logic [7:0] i_source_enable,
  input wire logic i_stop_when_full,
  input wire logic i_queue_enable,
  input wire logic i_motion_wake,
  input wire logic i_overrun_clear,
  // power and clock control
  output logic o_sleep,
  output logic o_asleep,
  output logic o_cycle_wake,
  output logic o_capture,
  output logic o_thermal_sensor_off,
  output logic [2:0] o_axis_off,
  output logic o_use_pll,
  output logic o_clock_stop,
  output logic o_timing_reset,
  // queue status
  output logic o_queue_overrun_flag
);

  // lowest set bit of a source mask, used for ordered loading
  function automatic logic [2:0] lowest_set(input logic [7:0] mask);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = 7; k >= 0; k--)
    begin
      if (mask[k])
      begin
        idx = k[2:0];
      end
    end
    return idx;
  endfunction : lowest_set
  // a byte equal to the empty mark is stored one lower
  function automatic logic [7:0] sanitize(input logic [7:0] b);
    return (b == `QUEUE_EMPTY_MARK) ? `QUEUE_SUBSTITUTE : b;
  endfunction : sanitize
  // link side state
  logic busy, next_busy;
  logic req_tgl, next_req_tgl;
  logic hold_wr, next_hold_wr;
  logic [6:0] hold_addr, next_hold_addr;
  logic [7:0] hold_wdata, next_hold_wdata;
  logic [7:0] next_rdata;
  logic next_done;
  logic ack_s1, ack_s2, ack_s3;
  logic pin_s1, pin_s2;

  // core side state
  logic req_s1, req_s2, req_s3;
  logic pll_s1, pll_s2;
  logic ack_tgl, next_ack_tgl;
  logic [7:0] resp_data, next_resp_data;
  logic [7:0] power, next_power;
  logic [7:0] standby, next_standby;
  logic [12:0] snap, next_snap;
  logic [12:0] count, next_count;
  logic [11:0] rd_ptr, next_rd_ptr;
  logic [11:0] wr_ptr, next_wr_ptr;
  logic overrun, next_overrun;
  logic [63:0] ld_data, next_ld_data;
  logic [7:0] ld_mask, next_ld_mask;
  logic [7:0] queue_mem [0:4095];
  logic mem_we;
  logic [7:0] mem_wdata;
  power_fifo_pkg::cycle_state_t state, next_state;
  // combinational helpers of the core
  logic access, queue_on, full, pop, push, host_push, load_push, write_ok, drop_old;
  logic cycling, any_axis;
  logic [2:0] load_idx;
  logic [2:0] clk_code;

  // link side: take one access, hold it stable until the core answers
  always_comb
  begin
    next_busy = busy;
    next_req_tgl = req_tgl;
    next_hold_wr = hold_wr;
    next_hold_addr = hold_addr;
    next_hold_wdata = hold_wdata;
    next_rdata = o_reg_rdata;
    next_done = 1'b0;
    if (busy)
    begin
      if (ack_s2 != ack_s3)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_rdata = resp_data; // stable since the core wrote it in the same cycle as the toggle
      end
    end
    else if (i_reg_rd || i_reg_wr)
    begin
      // requests while busy are ignored; the held fields must not move under the core
      next_busy = 1'b1;
      next_req_tgl = ~req_tgl;
      next_hold_wr = i_reg_wr;
      next_hold_addr = i_reg_addr;
      next_hold_wdata = i_reg_wdata;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    if (!i_link_rst_b)
    begin
      busy <= 1'b0;
      req_tgl <= 1'b0;
      hold_wr <= 1'b0;
      hold_addr <= 7'h00;
      hold_wdata <= 8'h00;
      o_reg_rdata <= 8'h00;
      o_reg_done <= 1'b0;
      o_reg_busy <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      o_bus_address <= `BUS_ADDRESS_BASE;
    end
    else
    begin
      busy <= next_busy;
      req_tgl <= next_req_tgl;
      hold_wr <= next_hold_wr;
      hold_addr <= next_hold_addr;
      hold_wdata <= next_hold_wdata;
      o_reg_rdata <= next_rdata;
      o_reg_done <= next_done;
      o_reg_busy <= next_busy;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      pin_s1 <= i_address_select_pin;
      pin_s2 <= pin_s1;
      o_bus_address <= `BUS_ADDRESS_BASE | {6'h00, pin_s2};
    end
  end

  // core decode of the queue and access conditions
  always_comb
  begin
    access = req_s2 ^ req_s3;
    queue_on = i_queue_enable && (!i_motion_wake || standby[`STBY_LP_BIT]);
    full = (count == `QUEUE_DEPTH);
    pop = access && !hold_wr && (hold_addr == `ADDR_DATA_PORT) && queue_on
      && (count != 13'h0000);
    host_push = access && hold_wr && (hold_addr == `ADDR_DATA_PORT) && queue_on;
    load_push = (ld_mask != 8'h00) && !host_push && queue_on;
    push = host_push || load_push;
    load_idx = lowest_set(ld_mask);
    mem_wdata = host_push ? sanitize(hold_wdata) : sanitize(ld_data[{load_idx, 3'h0} +: 8]);
    write_ok = push && (!full || pop || !i_stop_when_full);
    drop_old = push && full && !pop && !i_stop_when_full;
    mem_we = write_ok;
    clk_code = power[2:0];
    cycling = power[`PWR_CYCLE_BIT] && !power[`PWR_SLEEP_BIT] && (clk_code != `CLK_STOPPED);
    any_axis = !(standby[`STBY_X_BIT] && standby[`STBY_Y_BIT] && standby[`STBY_Z_BIT]);
  end

  // core registers, queue pointers, loader and answer to the link
  always_comb
  begin
    next_power = power;
    next_standby = standby;
    next_snap = snap;
    next_resp_data = resp_data;
    next_ack_tgl = ack_tgl;
    next_ld_data = ld_data;
    next_ld_mask = ld_mask;
    next_wr_ptr = wr_ptr + {11'h000, write_ok};
    next_rd_ptr = rd_ptr + {11'h000, pop || drop_old};
    next_count = count + {12'h000, write_ok && !drop_old} - {12'h000, pop};
    // a new overflow wins over a clear in the same cycle
    next_overrun = (push && full && !pop) || (overrun && !i_overrun_clear);
    // a tick while a load is still draining restarts it with the fresh sample
    if (i_sample_tick && queue_on)
    begin
      next_ld_data = i_sensor_bytes;
      next_ld_mask = i_source_enable;
    end
    else if (load_push)
    begin
      next_ld_mask[load_idx] = 1'b0;
    end
    if (access)
    begin
      next_ack_tgl = ~ack_tgl;
      next_resp_data = 8'h00;
      if (hold_wr)
      begin
        if (hold_addr == `ADDR_POWER_CLOCK)
        begin
          if (hold_wdata[`PWR_RESET_BIT])
          begin
            // self-clearing device reset restores both control registers
            next_power = `PWR_RESET_VALUE;
            next_standby = `STBY_RESET_VALUE;
          end
          else
          begin
            next_power = hold_wdata & `PWR_WRITE_MASK;
          end
        end
        else if (hold_addr == `ADDR_AXIS_STANDBY)
        begin
          next_standby = hold_wdata & `STBY_WRITE_MASK;
        end
      end
      else
      begin
        case (hold_addr)
          `ADDR_POWER_CLOCK: next_resp_data = power;
          `ADDR_AXIS_STANDBY: next_resp_data = standby;
          `ADDR_LEVEL_HIGH:
          begin
            next_resp_data = {3'h0, count[12:8]};
            next_snap = count;
          end
          `ADDR_LEVEL_LOW: next_resp_data = snap[7:0];
          `ADDR_DATA_PORT: next_resp_data = pop ? queue_mem[rd_ptr] : `QUEUE_EMPTY_MARK;
          `ADDR_IDENTITY: next_resp_data = IDENTITY_VALUE;
          default: next_resp_data = 8'h00;
        endcase
      end
    end
  end

  // queue storage, written only when a byte is accepted
  always_ff @(posedge i_clk)
  begin
    if (mem_we)
    begin
      queue_mem[wr_ptr] <= mem_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
      ack_tgl <= 1'b0;
      resp_data <= 8'h00;
      power <= `PWR_RESET_VALUE;
      standby <= `STBY_RESET_VALUE;
      snap <= 13'h0000;
      count <= 13'h0000;
      rd_ptr <= 12'h000;
      wr_ptr <= 12'h000;
      overrun <= 1'b0;
      ld_data <= 64'h0000_0000_0000_0000;
      ld_mask <= 8'h00;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      pll_s1 <= i_pll_ready;
      pll_s2 <= pll_s1;
      ack_tgl <= next_ack_tgl;
      resp_data <= next_resp_data;
      power <= next_power;
      standby <= next_standby;
      snap <= next_snap;
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      overrun <= next_overrun;
      ld_data <= next_ld_data;
      ld_mask <= next_ld_mask;
    end
  end

  // duty cycling: doze until the wake tick, then one sample slot
  always_comb
  begin
    next_state = state;
    case (state)
      power_fifo_pkg::ST_AWAKE: next_state = cycling ? power_fifo_pkg::ST_DOZE : state;
      power_fifo_pkg::ST_DOZE:
      begin
        if (!cycling)
        begin
          next_state = power_fifo_pkg::ST_AWAKE;
        end
        else if (i_wake_tick)
        begin
          next_state = power_fifo_pkg::ST_SAMPLE;
        end
      end
      power_fifo_pkg::ST_SAMPLE:
      begin
        next_state = cycling ? power_fifo_pkg::ST_DOZE : power_fifo_pkg::ST_AWAKE;
      end
      default: next_state = power_fifo_pkg::ST_AWAKE;
    endcase
  end

  // outputs are registered copies so every pin comes from a flop
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      state <= power_fifo_pkg::ST_AWAKE;
      o_sleep <= 1'b0;
      o_asleep <= 1'b0;
      o_cycle_wake <= 1'b0;
      o_capture <= 1'b0;
      o_thermal_sensor_off <= 1'b0;
      o_axis_off <= 3'h0;
      o_use_pll <= 1'b0;
      o_clock_stop <= 1'b0;
      o_timing_reset <= 1'b0;
      o_queue_overrun_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_sleep <= power[`PWR_SLEEP_BIT];
      o_asleep <= power[`PWR_SLEEP_BIT] || (next_state == power_fifo_pkg::ST_DOZE);
      o_cycle_wake <= (next_state == power_fifo_pkg::ST_SAMPLE);
      o_capture <= (next_state == power_fifo_pkg::ST_SAMPLE) && any_axis;
      o_thermal_sensor_off <= power[`PWR_THERMAL_BIT];
      o_axis_off <= {standby[`STBY_X_BIT], standby[`STBY_Y_BIT], standby[`STBY_Z_BIT]};
      // internal oscillator for 0 and 6, and for 1-5 until the PLL reports ready
      o_use_pll <= (clk_code >= `CLK_PLL_FIRST) && (clk_code <= `CLK_PLL_LAST) && pll_s2;
      o_clock_stop <= (clk_code == `CLK_STOPPED);
      o_timing_reset <= (clk_code == `CLK_STOPPED);
      o_queue_overrun_flag <= overrun;
    end
  end

endmodule : power_fifo_register_bank

// *** sim/power_fifo_chk.sv ***
/*
  port checks of the power and queue register bank.
  assumes the bind at the foot attaches it to every bank.
*/
`timescale 1ns/10ps
module power_fifo_chk (
  // clocks and resets
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  input wire logic i_link_rst_b,
  // watched inputs
  input wire logic i_pll_ready,
  input wire logic i_overrun_clear,
  // watched outputs
  input wire logic o_reg_done,
  input wire logic o_reg_busy,
  input wire logic [6:0] o_bus_address,
  input wire logic o_cycle_wake,
  input wire logic o_capture,
  input wire logic o_asleep,
  input wire logic [2:0] o_axis_off,
  input wire logic o_use_pll,
  input wire logic o_clock_stop,
  input wire logic o_timing_reset,
  input wire logic o_queue_overrun_flag
);
  // access handshake on the link side
  a_done_pulse: assert property (@(posedge i_link_clk) disable iff (!i_link_rst_b)
    o_reg_done |-> !o_reg_busy ##1 !o_reg_done)
    else $error("done pulse too long");
  a_busy_bound: assert property (@(posedge i_link_clk) disable iff (!i_link_rst_b)
    $rose(o_reg_busy) |-> ##[1:8] o_reg_done)
    else $error("access never finished");
  a_address_base: assert property (@(posedge i_link_clk) disable iff (!i_link_rst_b)
    o_bus_address[6:1] == 6'h34)
    else $error("bus address outside pair");
  // clock source outputs; stop and pll are exclusive
  a_stop_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_timing_reset == o_clock_stop && !(o_clock_stop && o_use_pll))
    else $error("stop code outputs disagree");
  a_pll_ready: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_use_pll) |-> $past(i_pll_ready, 3))
    else $error("pll chosen while not ready");
  // duty cycling: a capture only with a wake and some axis on
  a_capture_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_capture |-> o_cycle_wake && o_axis_off != 3'b111)
    else $error("capture without wake or axis");
  a_wake_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_cycle_wake |-> !o_asleep ##1 !o_cycle_wake)
    else $error("wake pulse malformed");
  a_overrun_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_queue_overrun_flag && !$past(i_overrun_clear) |=> o_queue_overrun_flag)
    else $error("overrun flag lost");
endmodule : power_fifo_chk

bind power_fifo_register_bank power_fifo_chk chk (
  .i_clk, .i_rst_b, .i_link_clk, .i_link_rst_b, .i_pll_ready, .i_overrun_clear,
  .o_reg_done, .o_reg_busy, .o_bus_address, .o_cycle_wake, .o_capture, .o_asleep,
  .o_axis_off, .o_use_pll, .o_clock_stop, .o_timing_reset, .o_queue_overrun_flag
);

// *** sim/host_model.sv ***
/*
  host model: one register access at a time on the link clock.
  assumes a one-cycle done pulse answers every request.
*/
`timescale 1ns/10ps
`include "power_fifo_cfg.svh"
module host_model (
  // answers
  input wire logic i_link_clk,
  input wire logic i_reg_done,
  input wire logic [7:0] i_reg_rdata,
  // requests
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [6:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  // idle at time zero
  initial
  begin
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_addr = 7'h00;
    o_reg_wdata = 8'h00;
  end

  // request is a pulse: a held level would be taken again once done
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    int n = 0;
    ok = 1'b0;
    q = 8'h00;
    @(posedge i_link_clk);
    o_reg_rd <= !w;
    o_reg_wr <= w;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_link_clk);
    o_reg_rd <= 1'b0;
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
    while (!ok && n < 12)
    begin
      @(posedge i_link_clk);
      n++;
      if (i_reg_done === 1'b1)
      begin
        ok = 1'b1;
        q = i_reg_rdata;
      end
    end
  endtask : access

  // high byte first so both bytes come from one snapshot
  task automatic read_level(output logic [12:0] c, output logic ok);
    logic [7:0] h;
    logic [7:0] l;
    logic k;
    access(1'b0, `ADDR_LEVEL_HIGH, 8'h00, h, ok);
    access(1'b0, `ADDR_LEVEL_LOW, 8'h00, l, k);
    c = {h[4:0], l};
    ok = ok & k;
  endtask : read_level
endmodule : host_model

// *** sim/test_power_fifo_register_bank.sv ***
/*
  self-checking bench of the power and queue register bank.
  assumes host_model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`include "power_fifo_cfg.svh"
module test_power_fifo_register_bank;
  logic i_clk, i_rst_b, i_link_clk, i_link_rst_b, i_reg_rd, i_reg_wr, o_reg_done, o_reg_busy;
  logic [6:0] i_reg_addr, o_bus_address;
  logic [7:0] i_reg_wdata, o_reg_rdata, i_source_enable, q, v;
  logic i_address_select_pin, i_pll_ready, i_wake_tick, i_sample_tick, i_stop_when_full;
  logic [63:0] i_sensor_bytes, s;
  logic i_queue_enable, i_motion_wake, i_overrun_clear, o_sleep, o_asleep, o_cycle_wake;
  logic o_capture, o_thermal_sensor_off, o_use_pll, o_clock_stop, o_timing_reset;
  logic o_queue_overrun_flag;
  logic [2:0] o_axis_off;
  logic [12:0] lvl;
  logic [7:0] exp_q[$];
  int fail_count, total_checks;

  // identity differs from the default so a hard-wired value shows
  power_fifo_register_bank #(.IDENTITY_VALUE(8'h3C)) DUT (
    .i_clk, .i_rst_b, .i_link_clk, .i_link_rst_b, .i_reg_rd, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_done, .o_reg_busy, .i_address_select_pin,
    .o_bus_address, .i_pll_ready, .i_wake_tick, .i_sample_tick, .i_sensor_bytes,
    .i_source_enable, .i_stop_when_full, .i_queue_enable, .i_motion_wake, .i_overrun_clear,
    .o_sleep, .o_asleep, .o_cycle_wake, .o_capture, .o_thermal_sensor_off, .o_axis_off,
    .o_use_pll, .o_clock_stop, .o_timing_reset, .o_queue_overrun_flag
  );
  host_model host (
    .i_link_clk, .i_reg_done(o_reg_done), .i_reg_rdata(o_reg_rdata), .o_reg_rd(i_reg_rd),
    .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata)
  );

  // core clock 4 ns; link 80 ns on odd times so edges never meet
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    i_link_clk = 1'b0;
    #1;
    forever #40 i_link_clk = ~i_link_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // register access; a missing done ends the run
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic ok;
    host.access(w, a, d, q, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
  endtask : acc

  task automatic level();
    logic ok;
    host.read_level(lvl, ok);
    check("level done", ok, 1'b1);
    if (ok !== 1'b1) finish_test();
  endtask : level

  // the queue never holds the empty marker
  function automatic logic [7:0] stored(input logic [7:0] b);
    return (b == `QUEUE_EMPTY_MARK) ? `QUEUE_SUBSTITUTE : b;
  endfunction : stored

  function automatic logic pll_pick(input logic [2:0] c, input logic r);
    return c >= `CLK_PLL_FIRST && c <= `CLK_PLL_LAST && r;
  endfunction : pll_pick

  // one sample tick; loader needs a byte per cycle
  task automatic load(input logic [63:0] b, input logic [7:0] en);
    @(posedge i_clk);
    i_sensor_bytes <= b;
    i_source_enable <= en;
    i_sample_tick <= 1'b1;
    @(posedge i_clk);
    i_sample_tick <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask : load

  task automatic drain();
    while (exp_q.size() > 0)
    begin
      acc(1'b0, `ADDR_DATA_PORT, 8'h00);
      check("pop", q, exp_q.pop_front());
    end
    acc(1'b0, `ADDR_DATA_PORT, 8'h00);
    check("empty", q, 8'hFF);
  endtask : drain

  // wake pulse and the capture that should ride on it
  task automatic wake(input logic cap);
    int n = 0;
    @(posedge i_clk);
    i_wake_tick <= 1'b1;
    @(posedge i_clk);
    i_wake_tick <= 1'b0;
    while (o_cycle_wake !== 1'b1 && n < 8)
    begin
      @(posedge i_clk);
      n++;
    end
    check("wake", o_cycle_wake, 1'b1);
    check("capture", o_capture, cap);
    if (o_cycle_wake !== 1'b1) finish_test();
  endtask : wake

  // main sequence
  initial
  begin
    {i_rst_b, i_link_rst_b, i_pll_ready, i_wake_tick, i_sample_tick} = 5'h00;
    {i_stop_when_full, i_queue_enable, i_motion_wake, i_overrun_clear} = 4'h0;
    i_sensor_bytes = 64'h0;
    i_source_enable = 8'h00;
    void'($urandom(32'h42db_25cc));
    i_address_select_pin = 1'($urandom);
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_link_clk);
    i_link_rst_b <= 1'b1;
    acc(1'b0, `ADDR_POWER_CLOCK, 8'h00);
    check("power reset", q, `PWR_RESET_VALUE);
    acc(1'b0, `ADDR_AXIS_STANDBY, 8'h00);
    check("standby reset", q, `STBY_RESET_VALUE);
    acc(1'b1, `ADDR_IDENTITY, 8'hC3);
    acc(1'b0, `ADDR_IDENTITY, 8'h00);
    check("identity", q, 8'h3C);
    acc(1'b0, 7'h10, 8'h00);
    check("unmapped", q, 8'h00);
    check("bus address", o_bus_address, {6'h34, i_address_select_pin});
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      v = {4'h0, 1'($urandom), 3'(c)};
      i_pll_ready <= 1'($urandom);
      acc(1'b1, `ADDR_POWER_CLOCK, v);
      check("use pll", o_use_pll, pll_pick(v[2:0], i_pll_ready));
      check("stop", o_clock_stop, v[2:0] == `CLK_STOPPED);
      check("timing reset", o_timing_reset, v[2:0] == `CLK_STOPPED);
      check("thermal", o_thermal_sensor_off, v[3]);
      acc(1'b0, `ADDR_POWER_CLOCK, 8'h00);
      check("power back", q, v);
    end
    acc(1'b1, `ADDR_POWER_CLOCK, 8'h41);
    check("sleep", o_sleep, 1'b1);
    check("asleep", o_asleep, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      acc(1'b1, `ADDR_AXIS_STANDBY, v);
      check("axis off", o_axis_off, {v[5], v[4], v[3]});
      acc(1'b0, `ADDR_AXIS_STANDBY, 8'h00);
      check("standby back", q, v & `STBY_WRITE_MASK);
    end
    $display("test control done");
    acc(1'b1, `ADDR_AXIS_STANDBY, 8'h00);
    i_queue_enable <= 1'b1;
    i_motion_wake <= 1'b1;
    acc(1'b1, `ADDR_DATA_PORT, 8'h12);
    acc(1'b1, `ADDR_AXIS_STANDBY, 8'h80);
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? 8'hFF : 8'($urandom);
      acc(1'b1, `ADDR_DATA_PORT, v);
      exp_q.push_back(stored(v));
    end
    acc(1'b0, `ADDR_LEVEL_HIGH, 8'h00);
    check("level high", q, 8'h00);
    acc(1'b1, `ADDR_DATA_PORT, 8'h5B);
    exp_q.push_back(8'h5B);
    acc(1'b0, `ADDR_LEVEL_LOW, 8'h00);
    check("level snapshot", q, 8'h03);
    drain();
    i_queue_enable <= 1'b0;
    acc(1'b1, `ADDR_DATA_PORT, 8'h34);
    i_queue_enable <= 1'b1;
    level();
    check("gated level", lvl, 13'h0);
    $display("test port done");
    for (int k = 0; k < 3; k++)
    begin
      s = {$urandom, $urandom};
      v = (k == 0) ? 8'hFF : 8'($urandom);
      load(s, v);
      for (int j = 0; j < 8; j++)
        if (v[j])
          exp_q.push_back(stored(s[8*j +: 8]));
      level();
      check("sample level", lvl, 13'(exp_q.size()));
      drain();
    end
    $display("test sample done");
    i_stop_when_full <= 1'b1;
    for (int k = 0; k < 512; k++)
      load({8{1'b0, 7'(k)}}, 8'hFF);
    load({8{8'h77}}, 8'hFF);
    check("overrun", o_queue_overrun_flag, 1'b1);
    level();
    check("full level", lvl, 13'h1000);
    acc(1'b0, `ADDR_DATA_PORT, 8'h00);
    check("kept oldest", q, 8'h00);
    i_stop_when_full <= 1'b0;
    load({8{8'h55}}, 8'hFF);
    acc(1'b0, `ADDR_DATA_PORT, 8'h00);
    check("lost oldest", q, 8'h01);
    i_overrun_clear <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_overrun_clear <= 1'b0;
    repeat (2) @(posedge i_clk);
    check("overrun clear", o_queue_overrun_flag, 1'b0);
    $display("test overflow done");
    acc(1'b1, `ADDR_AXIS_STANDBY, 8'h80);
    acc(1'b1, `ADDR_POWER_CLOCK, 8'h21);
    wake(1'b1);
    acc(1'b1, `ADDR_AXIS_STANDBY, 8'hB8);
    wake(1'b0);
    acc(1'b1, `ADDR_POWER_CLOCK, 8'h80);
    acc(1'b0, `ADDR_POWER_CLOCK, 8'h00);
    check("device reset power", q, `PWR_RESET_VALUE);
    acc(1'b0, `ADDR_AXIS_STANDBY, 8'h00);
    check("device reset standby", q, `STBY_RESET_VALUE);
    check("axes back on", o_axis_off, 3'h0);
    $display("test cycle done");
    finish_test();
  end
endmodule : test_power_fifo_register_bank
